// [verilog/ctbfo_pkg.sv]
package ctbfo_pkg;
    //------------------------------------------------------------------
    // Bus geometry
    //------------------------------------------------------------------
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned BE_W   = 4;

    //------------------------------------------------------------------
    // Register byte offsets
    //------------------------------------------------------------------
    localparam logic [7:0] OFS_CMD   = 8'h00;
    localparam logic [7:0] OFS_STAT  = 8'h04;
    localparam logic [7:0] OFS_GSEL  = 8'h08;
    localparam logic [7:0] OFS_GDATA = 8'h0C;
    localparam logic [7:0] OFS_ISEL  = 8'h10;
    localparam logic [7:0] OFS_IDATA = 8'h14;
    localparam logic [7:0] OFS_PSEL  = 8'h18;
    localparam logic [7:0] OFS_PDATA = 8'h1C;
    localparam logic [7:0] OFS_SPTR  = 8'h20;

    //------------------------------------------------------------------
    // Command word fields
    //------------------------------------------------------------------
    localparam int unsigned OP_LSB    = 0;
    localparam int unsigned OP_W      = 6;
    localparam int unsigned RD_LSB    = 8;
    localparam int unsigned RD_W      = 5;
    localparam int unsigned BIT_LSB   = 16;
    localparam int unsigned BIT_W     = 3;
    localparam int unsigned IO_LSB    = 24;
    localparam int unsigned IO_W      = 6;
    localparam int unsigned STAT_BUSY = 8;

    //------------------------------------------------------------------
    // Status register bits, reset values, pointer pair
    //------------------------------------------------------------------
    localparam int unsigned SR_C = 0;
    localparam int unsigned SR_Z = 1;
    localparam int unsigned SR_N = 2;
    localparam int unsigned SR_V = 3;
    localparam int unsigned SR_S = 4;
    localparam int unsigned SR_H = 5;
    localparam int unsigned SR_T = 6;
    localparam int unsigned SR_I = 7;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] SP_RST     = 8'hFF;
    localparam logic [4:0] ZLO_IDX    = 5'h1E;
    localparam logic [4:0] ZHI_IDX    = 5'h1F;
    localparam logic [4:0] R0_IDX     = 5'h00;
    localparam logic [4:0] R1_IDX     = 5'h01;

    //------------------------------------------------------------------
    // Cycle counts
    //------------------------------------------------------------------
    localparam logic [1:0] CYC_ONE        = 2'h1;
    localparam logic [1:0] CYC_TWO        = 2'h2;
    localparam logic [1:0] CYC_PMEM_LOAD  = 2'h3;
    localparam logic [1:0] CYC_PMEM_STORE = 2'h2;

    //------------------------------------------------------------------
    // Opcodes; dedicated flag ops are {OP_FLAG_TAG, bit index, value}
    //------------------------------------------------------------------
    localparam logic [5:0] OP_NOP          = 6'h00;
    localparam logic [5:0] OP_PMEM_LOAD    = 6'h01;
    localparam logic [5:0] OP_PMEM_STORE   = 6'h02;
    localparam logic [5:0] OP_IN           = 6'h03;
    localparam logic [5:0] OP_OUT          = 6'h04;
    localparam logic [5:0] OP_PUSH         = 6'h05;
    localparam logic [5:0] OP_POP          = 6'h06;
    localparam logic [5:0] OP_IO_BIT_SET   = 6'h07;
    localparam logic [5:0] OP_IO_BIT_CLEAR = 6'h08;
    localparam logic [5:0] OP_SHIFT_LEFT   = 6'h09;
    localparam logic [5:0] OP_SHIFT_RIGHT  = 6'h0A;
    localparam logic [5:0] OP_ROT_LEFT     = 6'h0B;
    localparam logic [5:0] OP_ROT_RIGHT    = 6'h0C;
    localparam logic [5:0] OP_ARITH_RIGHT  = 6'h0D;
    localparam logic [5:0] OP_SWAP         = 6'h0E;
    localparam logic [5:0] OP_IDX_FLAG_SET = 6'h0F;
    localparam logic [5:0] OP_IDX_FLAG_CLR = 6'h10;
    localparam logic [5:0] OP_BIT_TO_T     = 6'h11;
    localparam logic [5:0] OP_T_TO_BIT     = 6'h12;
    localparam logic [1:0] OP_FLAG_TAG     = 2'b10;
    localparam logic [5:0] OP_CARRY_CLR    = 6'h20;
    localparam logic [5:0] OP_CARRY_SET    = 6'h21;
    localparam logic [5:0] OP_ZERO_CLR     = 6'h22;
    localparam logic [5:0] OP_ZERO_SET     = 6'h23;
    localparam logic [5:0] OP_NEG_CLR      = 6'h24;
    localparam logic [5:0] OP_NEG_SET      = 6'h25;
    localparam logic [5:0] OP_OVF_CLR      = 6'h26;
    localparam logic [5:0] OP_OVF_SET      = 6'h27;
    localparam logic [5:0] OP_SIGNED_CLR   = 6'h28;
    localparam logic [5:0] OP_SIGNED_SET   = 6'h29;
    localparam logic [5:0] OP_TFLAG_CLR    = 6'h2C;
    localparam logic [5:0] OP_TFLAG_SET    = 6'h2D;
    localparam logic [5:0] OP_IRQ_DISABLE  = 6'h2E;
    localparam logic [5:0] OP_IRQ_ENABLE   = 6'h2F;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } ctbfo_state_t;
endpackage

// [verilog/ctbfo_core.sv]
// Overview of operation
// - Program load puts byte at Z into destination (not r30/r31, where Z+1 wins), increments Z, 3 cycles.
// - Push writes source to stack, moves pointer down, 2 cycles, no flags.
// - Pop loads destination from stack, moves pointer up, 2 cycles, no flags.
// - I/O bit set forces one bit high, others kept, 2 cycles.
// - I/O bit clear forces one bit low, others kept, 2 cycles.
// - Left shift fills bit 0 with zero, updates Z C N V, 1 cycle.
// - Right shift fills bit 7 with zero, updates Z C N V, 1 cycle.
// - Rotate left via carry: old carry to bit 0, bit 7 to carry.
// - Rotate right via carry: old carry to bit 7, bit 0 to carry.
// - Arithmetic right shift keeps bit 7, updates Z C N V, 1 cycle.
// - Bit store copies selected register bit into T only, 1 cycle.
// - Bit load copies T into selected register bit, no flags, 1 cycle.
// - Signed flag set writes S to one, nothing else.
// - Signed flag clear writes S to zero, nothing else.
// - Overflow set writes V to one, nothing else.
// - Overflow clear writes V to zero, nothing else.
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
module ctbfo_core (
    // Clock and reset
    input  wire logic                          mclk_in,
    input  wire logic                          rst_in,
    // Avalon-MM slave
    input  wire logic [ctbfo_pkg::ADDR_W-1:0]  avs_address_in,
    input  wire logic                          avs_read_in,
    input  wire logic                          avs_write_in,
    input  wire logic [ctbfo_pkg::DATA_W-1:0]  avs_writedata_in,
    input  wire logic [ctbfo_pkg::BE_W-1:0]    avs_byteenable_in,
    output logic      [ctbfo_pkg::DATA_W-1:0]  avs_readdata_out,
    output logic                               avs_waitrequest_out,
    // Execution state
    output logic                               busy_out
);
    import ctbfo_pkg::*;

    //------------------------------------------------------------------
    // Storage
    //------------------------------------------------------------------
    logic [7:0]   gpr_mem [0:31];
    logic [7:0]   io_mem  [0:63];
    logic [7:0]   stk_mem [0:255];
    logic [15:0]  pm_mem  [0:255];
    logic [7:0]   status_reg;
    logic [7:0]   sp_reg;
    logic [31:0]  cmd_reg;
    logic [4:0]   gsel_reg;
    logic [5:0]   isel_reg;
    logic [7:0]   psel_reg;
    ctbfo_state_t state_reg;
    logic [1:0]   cnt_reg;
    logic         wait_reg;
    logic [31:0]  rdata_reg;
    logic [7:0]   prev_rd_reg;
    logic [7:0]   prev_status_reg;

    //------------------------------------------------------------------
    // Decode
    //------------------------------------------------------------------
    function automatic logic [1:0] op_cycles(input logic [5:0] op);
        case (op)
            OP_PMEM_LOAD:    op_cycles = CYC_PMEM_LOAD;
            OP_PMEM_STORE:   op_cycles = CYC_PMEM_STORE;
            OP_PUSH,
            OP_POP,
            OP_IO_BIT_SET,
            OP_IO_BIT_CLEAR: op_cycles = CYC_TWO;
            default:         op_cycles = CYC_ONE;
        endcase
    endfunction

    logic [31:0] wdata_m;
    logic        wr_acc;
    logic        start;
    logic        fire;
    logic [5:0]  op_f;
    logic [5:0]  op_in;
    logic [4:0]  rd_f;
    logic [2:0]  bit_f;
    logic [5:0]  io_f;
    logic [7:0]  rd_val;
    logic [15:0] z_ptr;

    assign wdata_m = avs_writedata_in & {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                                         {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
    assign wr_acc  = avs_write_in && !wait_reg;
    assign start   = wr_acc && (avs_address_in == OFS_CMD);
    assign fire    = (state_reg == ST_RUN) && (cnt_reg == 2'h0);
    assign op_f    = cmd_reg[OP_LSB +: OP_W];
    assign op_in   = wdata_m[OP_LSB +: OP_W];
    assign rd_f    = cmd_reg[RD_LSB +: RD_W];
    assign bit_f   = cmd_reg[BIT_LSB +: BIT_W];
    assign io_f    = cmd_reg[IO_LSB +: IO_W];
    assign rd_val  = gpr_mem[rd_f];
    assign z_ptr   = {gpr_mem[ZHI_IDX], gpr_mem[ZLO_IDX]};

    //------------------------------------------------------------------
    // Result and flag computation
    //------------------------------------------------------------------
    logic [7:0] res;
    logic [7:0] flags;
    logic       wr_gpr;
    logic       shift_op;
    logic       c_out;

    always_comb begin
        res      = rd_val;
        flags    = status_reg;
        wr_gpr   = 1'b0;
        shift_op = 1'b0;
        c_out    = status_reg[SR_C];
        case (op_f)
            OP_PMEM_LOAD: begin
                res    = z_ptr[0] ? pm_mem[z_ptr[8:1]][15:8] : pm_mem[z_ptr[8:1]][7:0];
                wr_gpr = 1'b1;
            end
            OP_IN: begin
                res    = io_mem[io_f];
                wr_gpr = 1'b1;
            end
            OP_POP: begin
                res    = stk_mem[8'(sp_reg + 8'h01)];
                wr_gpr = 1'b1;
            end
            OP_SHIFT_LEFT: begin
                res      = {rd_val[6:0], 1'b0};
                c_out    = rd_val[7];
                shift_op = 1'b1;
            end
            OP_SHIFT_RIGHT: begin
                res      = {1'b0, rd_val[7:1]};
                c_out    = rd_val[0];
                shift_op = 1'b1;
            end
            OP_ROT_LEFT: begin
                res      = {rd_val[6:0], status_reg[SR_C]};
                c_out    = rd_val[7];
                shift_op = 1'b1;
            end
            OP_ROT_RIGHT: begin
                res      = {status_reg[SR_C], rd_val[7:1]};
                c_out    = rd_val[0];
                shift_op = 1'b1;
            end
            OP_ARITH_RIGHT: begin
                res      = {rd_val[7], rd_val[7:1]};
                c_out    = rd_val[0];
                shift_op = 1'b1;
            end
            OP_SWAP: begin
                res    = {rd_val[3:0], rd_val[7:4]};
                wr_gpr = 1'b1;
            end
            OP_T_TO_BIT: begin
                res[bit_f] = status_reg[SR_T];
                wr_gpr     = 1'b1;
            end
            OP_BIT_TO_T:     flags[SR_T]  = rd_val[bit_f];
            OP_IDX_FLAG_SET: flags[bit_f] = 1'b1;
            OP_IDX_FLAG_CLR: flags[bit_f] = 1'b0;
            default: begin
                // Dedicated flag ops carry index and value in the opcode
                if (op_f[5:4] == OP_FLAG_TAG) begin
                    flags[op_f[3:1]] = op_f[0];
                end
            end
        endcase
        if (shift_op) begin
            wr_gpr      = 1'b1;
            flags[SR_C] = c_out;
            flags[SR_Z] = (res == 8'h00);
            flags[SR_N] = res[7];
            flags[SR_V] = res[7] ^ c_out;
        end
    end

    //------------------------------------------------------------------
    // Sequencer
    //------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 2'h0;
            cmd_reg   <= 32'h0000_0000;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        state_reg <= ST_RUN;
                        cmd_reg   <= wdata_m;
                        cnt_reg   <= 2'(op_cycles(op_in) - 2'h1);
                    end
                end
                ST_RUN: begin
                    if (cnt_reg == 2'h0) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= 2'(cnt_reg - 2'h1);
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    assign busy_out = state_reg[1];

    //------------------------------------------------------------------
    // Register file, Z post-increment
    //------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (wr_acc && avs_address_in == OFS_GDATA) begin
            gpr_mem[gsel_reg] <= wdata_m[7:0];
        end
        if (fire && wr_gpr) begin
            gpr_mem[rd_f] <= res;
        end
        if (fire && op_f == OP_PMEM_LOAD) begin
            {gpr_mem[ZHI_IDX], gpr_mem[ZLO_IDX]} <= 16'(z_ptr + 16'h0001);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            status_reg <= STATUS_RST;
        end else if (fire) begin
            status_reg <= flags;
        end
    end

    //------------------------------------------------------------------
    // I/O space
    //------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (wr_acc && avs_address_in == OFS_IDATA) begin
            io_mem[isel_reg] <= wdata_m[7:0];
        end
        if (fire) begin
            case (op_f)
                OP_OUT:          io_mem[io_f]        <= rd_val;
                OP_IO_BIT_SET:   io_mem[io_f][bit_f] <= 1'b1;
                OP_IO_BIT_CLEAR: io_mem[io_f][bit_f] <= 1'b0;
                default: ;
            endcase
        end
    end

    //------------------------------------------------------------------
    // Stack and program memory
    //------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            sp_reg <= SP_RST;
        end else if (wr_acc && avs_address_in == OFS_SPTR) begin
            sp_reg <= wdata_m[7:0];
        end else if (fire && op_f == OP_PUSH) begin
            sp_reg <= 8'(sp_reg - 8'h01);
        end else if (fire && op_f == OP_POP) begin
            sp_reg <= 8'(sp_reg + 8'h01);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (fire && op_f == OP_PUSH) begin
            stk_mem[sp_reg] <= rd_val;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (wr_acc && avs_address_in == OFS_PDATA) begin
            pm_mem[psel_reg] <= wdata_m[15:0];
        end else if (fire && op_f == OP_PMEM_STORE) begin
            pm_mem[z_ptr[8:1]] <= {gpr_mem[R1_IDX], gpr_mem[R0_IDX]};
        end
    end

    //------------------------------------------------------------------
    // Avalon slave: one wait cycle, writes stall while busy
    //------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= !(wait_reg && (avs_read_in || (avs_write_in && !busy_out)));
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            gsel_reg <= 5'h00;
            isel_reg <= 6'h00;
            psel_reg <= 8'h00;
        end else if (wr_acc) begin
            case (avs_address_in)
                OFS_GSEL: gsel_reg <= wdata_m[4:0];
                OFS_ISEL: isel_reg <= wdata_m[5:0];
                OFS_PSEL: psel_reg <= wdata_m[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rdata_reg <= 32'h0000_0000;
        end else if (wait_reg && avs_read_in) begin
            case (avs_address_in)
                OFS_CMD:   rdata_reg <= cmd_reg;
                OFS_STAT:  rdata_reg <= {23'h000000, busy_out, status_reg};
                OFS_GSEL:  rdata_reg <= {27'h0000000, gsel_reg};
                OFS_GDATA: rdata_reg <= {24'h000000, gpr_mem[gsel_reg]};
                OFS_ISEL:  rdata_reg <= {26'h0000000, isel_reg};
                OFS_IDATA: rdata_reg <= {24'h000000, io_mem[isel_reg]};
                OFS_PSEL:  rdata_reg <= {24'h000000, psel_reg};
                OFS_PDATA: rdata_reg <= {16'h0000, pm_mem[psel_reg]};
                OFS_SPTR:  rdata_reg <= {24'h000000, sp_reg};
                default:   rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    assign avs_readdata_out    = rdata_reg;
    assign avs_waitrequest_out = wait_reg;

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        prev_rd_reg     <= rd_val;
        prev_status_reg <= status_reg;
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    a_pmem_load_time: assert property (
        start && op_in == OP_PMEM_LOAD |=> !fire [*2] ##1 fire
    ) else $error("program load not three cycles");
    a_pmem_zinc: assert property (
        fire && op_f == OP_PMEM_LOAD && rd_f < ZLO_IDX
        |=> z_ptr == 16'($past(z_ptr) + 16'h0001) && status_reg == prev_status_reg
    ) else $error("Z not incremented");
    a_stack_time: assert property (
        start && (op_in == OP_PUSH || op_in == OP_IO_BIT_SET) |=> !fire ##1 fire
    ) else $error("two-cycle op wrong length");
    a_pop_sp: assert property (
        fire && op_f == OP_POP |=> sp_reg == 8'($past(sp_reg) + 8'h01)
    ) else $error("pop pointer wrong");
    a_io_bit_clear: assert property (
        fire && op_f == OP_IO_BIT_CLEAR |=> io_mem[io_f][bit_f] == 1'b0
    ) else $error("io bit not cleared");
    a_shl_result: assert property (
        fire && op_f == OP_SHIFT_LEFT
        |=> rd_val == {prev_rd_reg[6:0], 1'b0} && status_reg[SR_C] == prev_rd_reg[7]
    ) else $error("left shift wrong");
    a_rotr_carry: assert property (
        fire && op_f == OP_ROT_RIGHT
        |=> rd_val[7] == prev_status_reg[SR_C] && status_reg[SR_C] == prev_rd_reg[0]
    ) else $error("rotate right wrong");
    a_asr_sign: assert property (
        fire && op_f == OP_ARITH_RIGHT |=> rd_val[7] == prev_rd_reg[7]
        && status_reg[SR_Z] == (rd_val == 8'h00) && status_reg[SR_S] == prev_status_reg[SR_S]
    ) else $error("arith shift wrong");
    a_bst_only_t: assert property (
        fire && op_f == OP_BIT_TO_T
        |=> status_reg[5:0] == prev_status_reg[5:0] && status_reg[SR_I] == prev_status_reg[SR_I]
    ) else $error("bit store touched other flags");
    a_ovf_set: assert property (
        fire && op_f == OP_OVF_SET
        |=> status_reg == (prev_status_reg | 8'h08)
    ) else $error("overflow set wrong");
    a_swap_flags: assert property (
        fire && op_f == OP_SWAP
        |=> rd_val == {prev_rd_reg[3:0], prev_rd_reg[7:4]} && $stable(status_reg)
    ) else $error("swap wrong");
endmodule

// [verif/ctbfo_core_bench.sv]
module ctbfo_core_bench import ctbfo_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    logic        mclk_in;
    logic        rst_in;
    logic [7:0]  avs_address_in;
    logic        avs_read_in;
    logic        avs_write_in;
    logic [31:0] avs_writedata_in;
    logic [3:0]  avs_byteenable_in;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic        busy_out;
    int          errors;
    int          checks_done;
    logic [7:0]  sr;
    logic [31:0] q;

    ctbfo_core DUT (
        .mclk_in             (mclk_in),
        .rst_in              (rst_in),
        .avs_address_in      (avs_address_in),
        .avs_read_in         (avs_read_in),
        .avs_write_in        (avs_write_in),
        .avs_writedata_in    (avs_writedata_in),
        .avs_byteenable_in   (avs_byteenable_in),
        .avs_readdata_out    (avs_readdata_out),
        .avs_waitrequest_out (avs_waitrequest_out),
        .busy_out            (busy_out)
    );

    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end

    //------------------------------------------------------------------
    // Report, compare and bus tasks
    //------------------------------------------------------------------
    task automatic summarize();
        $display("Counts: %0d compares, %0d mismatches", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // Starts right after an edge, holds until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= w;
        avs_read_in <= ~w;
        do begin
            @(posedge mclk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 40);
        if (n >= 40) begin
            chk(32'h1, 32'h0, "bus timeout");
            summarize();
        end
        q = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        @(posedge mclk_in);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
        bus(1'b0, a, 32'h0);
        @(posedge mclk_in);
        chk(q, exp, m);
    endtask

    // Select register at s, data register at s+4
    task automatic put(input logic [7:0] s, input logic [7:0] i, input logic [15:0] v);
        wr(s, {24'h0, i});
        wr(s + 8'h04, {16'h0, v});
    endtask

    task automatic get(input logic [7:0] s, input logic [7:0] i, input logic [15:0] v);
        wr(s, {24'h0, i});
        rd(s + 8'h04, {16'h0, v}, "select data");
    endtask

    // Issues one command, counts busy cycles, then checks status
    task automatic exec(input logic [5:0] op, input logic [4:0] r, input logic [2:0] b,
                        input logic [5:0] p, input int nc);
        int n;
        n = 0;
        bus(1'b1, OFS_CMD, {2'h0, p, 5'h00, b, 3'h0, r, 2'h0, op});
        @(posedge mclk_in);
        while (busy_out === 1'b1 && n < 20) begin
            n++;
            @(posedge mclk_in);
        end
        chk(32'(n), 32'(nc), "cycles");
        if (n >= 20) begin
            summarize();
        end
        rd(OFS_STAT, {24'h0, sr}, "status");
    endtask

    //------------------------------------------------------------------
    // Scenarios
    //------------------------------------------------------------------
    task automatic t_flags();
        for (int i = 0; i < 8; i++) begin
            sr[i] = 1'b1;
            exec({OP_FLAG_TAG, 3'(i), 1'b1}, 5'h0, 3'h0, 6'h0, 1);
        end
        for (int i = 0; i < 8; i++) begin
            sr[i] = 1'b0;
            exec(OP_IDX_FLAG_CLR, 5'h00, 3'(i), 6'h00, 1);
        end
        for (int i = 0; i < 8; i++) begin
            sr[i] = 1'b1;
            exec(OP_IDX_FLAG_SET, 5'h00, 3'(i), 6'h00, 1);
        end
        for (int i = 0; i < 8; i++) begin
            sr[i] = 1'b0;
            exec({OP_FLAG_TAG, 3'(i), 1'b0}, 5'h0, 3'h0, 6'h0, 1);
        end
        $display("test flags done");
    endtask

    task automatic t_shift();
        logic [5:0] ops [6];
        logic [7:0] v;
        logic [7:0] r;
        logic       nc;
        ops = '{OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_ROT_LEFT, OP_ROT_RIGHT, OP_ARITH_RIGHT, OP_SWAP};
        for (int k = 0; k < 6; k++) begin
            for (int j = 0; j < 2; j++) begin
                v = (j == 0) ? 8'h80 : 8'h41;
                sr[SR_C] = j[0];
                exec({OP_FLAG_TAG, 3'(SR_C), j[0]}, 5'h00, 3'h0, 6'h00, 1);
                case (ops[k])
                    OP_SHIFT_LEFT:  {nc, r} = {v, 1'b0};
                    OP_SHIFT_RIGHT: {r, nc} = {1'b0, v};
                    OP_ROT_LEFT:    {nc, r} = {v, sr[SR_C]};
                    OP_ROT_RIGHT:   {r, nc} = {sr[SR_C], v};
                    OP_ARITH_RIGHT: {r, nc} = {v[7], v};
                    default:        {nc, r} = {sr[SR_C], v[3:0], v[7:4]};
                endcase
                sr[SR_C] = nc;
                sr[SR_Z] = (ops[k] == OP_SWAP) ? sr[SR_Z] : (r == 8'h00);
                sr[SR_N] = (ops[k] == OP_SWAP) ? sr[SR_N] : r[7];
                sr[SR_V] = (ops[k] == OP_SWAP) ? sr[SR_V] : r[7] ^ nc;
                put(OFS_GSEL, 8'h06, {8'h00, v});
                exec(ops[k], 5'h06, 3'h0, 6'h00, 1);
                get(OFS_GSEL, 8'h06, {8'h00, r});
            end
        end
        $display("test shift done");
    endtask

    task automatic t_bits_io();
        put(OFS_GSEL, 8'h09, 16'h0008);
        put(OFS_GSEL, 8'h0A, 16'h0000);
        sr[SR_T] = 1'b1;
        exec(OP_BIT_TO_T, 5'h09, 3'h3, 6'h00, 1);
        exec(OP_T_TO_BIT, 5'h0A, 3'h6, 6'h00, 1);
        get(OFS_GSEL, 8'h0A, 16'h0040);
        sr[SR_T] = 1'b0;
        exec(OP_BIT_TO_T, 5'h09, 3'h0, 6'h00, 1);
        exec(OP_T_TO_BIT, 5'h0A, 3'h6, 6'h00, 1);
        get(OFS_GSEL, 8'h0A, 16'h0000);
        put(OFS_ISEL, 8'h05, 16'h005A);
        exec(OP_IO_BIT_SET, 5'h00, 3'h0, 6'h05, 2);
        get(OFS_ISEL, 8'h05, 16'h005B);
        exec(OP_IO_BIT_CLEAR, 5'h00, 3'h6, 6'h05, 2);
        get(OFS_ISEL, 8'h05, 16'h001B);
        exec(OP_IN, 5'h0B, 3'h0, 6'h05, 1);
        get(OFS_GSEL, 8'h0B, 16'h001B);
        put(OFS_GSEL, 8'h0C, 16'h00C3);
        exec(OP_OUT, 5'h0C, 3'h0, 6'h09, 1);
        get(OFS_ISEL, 8'h09, 16'h00C3);
        $display("test bits and io done");
    endtask

    task automatic t_mem();
        put(OFS_GSEL, 8'h02, 16'h00A5);
        exec(OP_PUSH, 5'h02, 3'h0, 6'h00, 2);
        rd(OFS_SPTR, 32'h0000_00FE, "push pointer");
        exec(OP_POP, 5'h03, 3'h0, 6'h00, 2);
        rd(OFS_SPTR, 32'h0000_00FF, "pop pointer");
        get(OFS_GSEL, 8'h03, 16'h00A5);
        put(OFS_PSEL, 8'h12, 16'hBEEF);
        put(OFS_GSEL, 8'h1E, 16'h0025);
        put(OFS_GSEL, 8'h1F, 16'h0000);
        exec(OP_PMEM_LOAD, 5'h04, 3'h0, 6'h00, 3);
        get(OFS_GSEL, 8'h04, 16'h00BE);
        get(OFS_GSEL, 8'h1E, 16'h0026);
        put(OFS_GSEL, 8'h00, 16'h0034);
        put(OFS_GSEL, 8'h01, 16'h0012);
        put(OFS_GSEL, 8'h1E, 16'h0040);
        exec(OP_PMEM_STORE, 5'h00, 3'h0, 6'h00, 2);
        get(OFS_PSEL, 8'h20, 16'h1234);
        $display("test memory done");
    endtask

    //------------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------------
    initial begin
        rst_in = 1'b1;
        avs_address_in = 8'h00;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_writedata_in = 32'h0;
        avs_byteenable_in = 4'hF;
        errors = 0;
        checks_done = 0;
        sr = 8'h00;
        repeat (8) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        rd(OFS_STAT, 32'h0, "status after reset");
        rd(OFS_SPTR, 32'h0000_00FF, "pointer after reset");
        rd(8'h40, 32'h0, "unmapped read");
        $display("test reset done");
        t_flags();
        t_shift();
        t_bits_io();
        t_mem();
        summarize();
    end
endmodule
